// ### rtl/wnc_cfg.svh
// Timing, field and reset constants for the wiper command controller.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef WNC_CFG_SVH
`define WNC_CFG_SVH
`define WNC_CLK_HZ 10000000
`define WNC_STORE_MS 25
`define WNC_STORE_CYC ((`WNC_CLK_HZ / 1000) * `WNC_STORE_MS)
`define WNC_RDY_PULSE_CYC 4
`define WNC_FRAME_BITS 24
`define WNC_CMD_MSB 23
`define WNC_CMD_LSB 20
`define WNC_ADDR_MSB 19
`define WNC_ADDR_LSB 16
`define WNC_DATA_MSB 9
`define WNC_WIPER_MID 10'h200
`define WNC_WIPER_MAX 10'h3ff
`define WNC_WIPER_MIN 10'h000
`endif

// ### rtl/wnc_pkg.sv
// Types shared by the wiper command controller.
// Assumes wnc_cfg.svh supplies the constants.
package wnc_pkg;
	typedef logic [9:0] wnc_wiper_t;
	typedef logic [23:0] wnc_frame_t;
	typedef logic [3:0] wnc_cmd_t;
	typedef enum logic [1:0] {WNC_IDLE, WNC_STORE, WNC_DONE} wnc_state_e;
endpackage

// ### rtl/wnc_ctrl.sv
// Serial command interpreter of a nonvolatile wiper setting.
// Assumes all pins are asynchronous to core_clk; link clock far slower than core_clk.
// Link clock must stay below a quarter of core_clk, or edges are lost in the synchroniser.
// reset_n stands in for power-on; the stored value then falls back to midscale.
// Behaviour
// - Wiper position output follows the scratchpad contents only; zero means terminal B.
// - Nonvolatile store lasts 25 ms; shift register locked meanwhile.
// - Completion flag is pulled low for a pulse after a store.
// - Code 0 idles, 1 and 8 restore, 2 and 3 (address zero only) store.
// - Codes 4/5 halve, 6/7 decrement, 12/13 double, 14/15 increment.
// - Code 9 reads back nonvolatile value, code 10 the scratchpad.
// - Code 0xB with address zero loads data into scratchpad.
// - Code 0x2 writes scratchpad into nonvolatile store.
// - Other commands echo the previous 24-bit frame on serial out.
// - At reset release scratchpad reloads from nonvolatile store.
// - Nonvolatile store starts at midscale.
// - Preset low forces midscale; its rising edge restores from store.
// - Empty chip-select strobe repeats last step or shift command.
// - Write protect low blocks scratchpad changes except restores and preset.
// - Serial out released whenever chip select is high.
// - Scratchpad rewrites unlimited; store writes counted as program cycles.
// - Frames are 24 bits, most significant bit first.
// - One input bit sampled per rising link clock edge.
// - Frame decoded only when chip select rises.
// - Completion flag marks 1, 2, 3, 8, 9, 10 and preset.
`timescale 1ns/1ns
`default_nettype none
`include "wnc_cfg.svh"
module wnc_ctrl
	import wnc_pkg::*;
#(
	parameter int STORE_CYC = `WNC_STORE_CYC
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic link_clk,
	input wire logic chip_sel_n,
	input wire logic ser_in,
	output logic ser_out_o,
	output logic ser_out_oe,
	input wire logic write_prot_n,
	input wire logic preset_strobe_n,
	output logic ready_o,
	output logic ready_oe,
	output logic [9:0] wiper_pos,
	output logic [15:0] program_cycles
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] clk_s, cs_s, din_s, wp_s, pr_s;
	logic clk_q, cs_q, pr_q;
	// Two flops per pin; the second stage is read, with a third held for clock, select and preset edges
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_s <= 2'h0;
			cs_s <= 2'h3;
			din_s <= 2'h0;
			wp_s <= 2'h3;
			pr_s <= 2'h3;
			clk_q <= 1'b0;
			cs_q <= 1'b1;
			pr_q <= 1'b1;
		end else begin
			clk_s <= {clk_s[0], link_clk};
			cs_s <= {cs_s[0], chip_sel_n};
			din_s <= {din_s[0], ser_in};
			wp_s <= {wp_s[0], write_prot_n};
			pr_s <= {pr_s[0], preset_strobe_n};
			clk_q <= clk_s[1];
			cs_q <= cs_s[1];
			pr_q <= pr_s[1];
		end
	end
	// Synchronised levels, and edges against the held third stage
	wire cs_low = !cs_s[1];
	wire clk_rise = clk_s[1] && !clk_q;
	wire cs_rise = cs_s[1] && !cs_q;
	wire pr_low = !pr_s[1];
	wire pr_rise = pr_s[1] && !pr_q;
	wire wp_on = !wp_s[1];
	// ----------------------------------------
	// Arithmetic helpers
	// ----------------------------------------
	// Saturating wiper adjustments, never wrap
	function automatic wnc_wiper_t adjust(input wnc_wiper_t v, input wnc_cmd_t c);
		wnc_wiper_t r;
		r = v;
		case (c)
			4'h4, 4'h5: r = v >> 1;
			4'h6, 4'h7: r = (v == `WNC_WIPER_MIN) ? v : v - 10'h001;
			4'hc, 4'hd: r = v[`WNC_DATA_MSB] ? `WNC_WIPER_MAX : {v[`WNC_DATA_MSB - 1:0], 1'b0};
			4'he, 4'hf: r = (v == `WNC_WIPER_MAX) ? v : v + 10'h001;
			default: r = v;
		endcase
		return r;
	endfunction
	// Steps and shifts are the commands an empty strobe may replay
	function automatic logic is_repeatable(input wnc_cmd_t c);
		return (c >= 4'h4 && c <= 4'h7) || (c >= 4'hc);
	endfunction
	// ----------------------------------------
	// Serial shifter
	// ----------------------------------------
	wnc_state_e state, next_state;
	wnc_frame_t shift, echo, out_sr;
	logic [4:0] bit_cnt;
	logic got_bits;
	// Shifter frozen for the whole store
	wire locked = (state == WNC_STORE);
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			shift <= 24'h000000;
			bit_cnt <= 5'h00;
			got_bits <= 1'b0;
			out_sr <= 24'h000000;
		end else if (cs_low && clk_rise && !locked) begin
			shift <= {shift[`WNC_CMD_MSB - 1:0], din_s[1]};
			out_sr <= {out_sr[`WNC_CMD_MSB - 1:0], 1'b0};
			got_bits <= 1'b1;
			bit_cnt <= (bit_cnt == 5'(`WNC_FRAME_BITS - 1)) ? 5'h00 : bit_cnt + 5'h01;
		end else if (cs_rise) begin
			bit_cnt <= 5'h00;
			got_bits <= 1'b0;
		end else if (!cs_low) begin
			out_sr <= echo;
		end
	end
	// released while deselected
	// Open drain: a one bit leaves the line to its pull-up, a zero pulls it low
	assign ser_out_oe = cs_low && !out_sr[`WNC_CMD_MSB];
	assign ser_out_o = 1'b0;
	// ----------------------------------------
	// Decode on chip-select rise
	// ----------------------------------------
	wnc_cmd_t cmd, last_cmd;
	wnc_wiper_t scratch, nv_val;
	// Store timer sized from the store length
	logic [STORE_CYC > 1 ? $clog2(STORE_CYC) : 1:0] store_cnt;
	logic [2:0] rdy_cnt;
	logic last_ok;
	// Scratchpad copy taken when a store starts
	wnc_wiper_t store_val;
	// execute on chip-select rise
	// A frame counts only when a whole multiple of 24 bits arrived
	wire frame_ok = cs_rise && got_bits && (bit_cnt == 5'h00) && !locked;
	wire strobe_rep = cs_rise && !got_bits && last_ok && !locked;
	// Empty strobe replays the remembered command
	assign cmd = strobe_rep ? last_cmd : shift[`WNC_CMD_MSB:`WNC_CMD_LSB];
	wire exec = frame_ok || strobe_rep;
	wire is_addr0 = (shift[`WNC_ADDR_MSB:`WNC_ADDR_LSB] == 4'h0);
	wire do_restore = exec && (cmd == 4'h1 || cmd == 4'h8);
	wire do_store = exec && !wp_on && (cmd == 4'h2 || (cmd == 4'h3 && is_addr0));
	wire do_write = exec && !wp_on && cmd == 4'hb && is_addr0;
	wire do_adj = exec && !wp_on && is_repeatable(cmd);
	wire done_evt = (exec && (cmd == 4'h1 || cmd == 4'h8 || cmd == 4'h9 || cmd == 4'ha))
		|| pr_rise;
	logic boot;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			nv_val <= `WNC_WIPER_MID;
			scratch <= `WNC_WIPER_MID;
			boot <= 1'b1;
			last_cmd <= 4'h0;
			last_ok <= 1'b0;
			echo <= 24'h000000;
		end else begin
			boot <= 1'b0;
			// preset forces midscale, restores on rise
			if (pr_low)
				scratch <= `WNC_WIPER_MID;
			else if (boot || pr_rise || do_restore)
				scratch <= nv_val;
			else if (do_write)
				scratch <= shift[`WNC_DATA_MSB:0];
			else if (do_adj)
				scratch <= adjust(scratch, cmd);
			// value committed at end of store time
			if (state == WNC_STORE && store_cnt == '0)
				nv_val <= store_val;
			if (frame_ok) begin
				last_cmd <= shift[`WNC_CMD_MSB:`WNC_CMD_LSB];
				last_ok <= is_repeatable(shift[`WNC_CMD_MSB:`WNC_CMD_LSB]);
			end
			// Readback words are zero-padded to a full frame
			// readback or echo
			if (frame_ok) begin
				if (cmd == 4'h9)
					echo <= {14'h0000, nv_val};
				else if (cmd == 4'ha)
					echo <= {14'h0000, scratch};
				else
					echo <= shift;
			end
		end
	end
	assign wiper_pos = scratch;
	// ----------------------------------------
	// Store timing and completion flag
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			WNC_IDLE: if (do_store) next_state = WNC_STORE;
			WNC_STORE: if (store_cnt == '0) next_state = WNC_DONE;
			WNC_DONE: next_state = WNC_IDLE;
			default: next_state = WNC_IDLE;
		endcase
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= WNC_IDLE;
			store_cnt <= '0;
			rdy_cnt <= 3'h0;
			program_cycles <= 16'h0000;
			store_val <= `WNC_WIPER_MID;
		end else begin
			state <= next_state;
			// Value latched at start, so a preset during the store cannot alter it
			if (do_store && state == WNC_IDLE) begin
				store_cnt <= ($bits(store_cnt))'(STORE_CYC - 1);
				store_val <= scratch;
			end else if (store_cnt != '0)
				store_cnt <= store_cnt - 1'b1;
			if (state == WNC_DONE)
				program_cycles <= program_cycles + 16'h0001;
			if (state == WNC_DONE || done_evt)
				rdy_cnt <= 3'(`WNC_RDY_PULSE_CYC);
			else if (rdy_cnt != 3'h0)
				rdy_cnt <= rdy_cnt - 3'h1;
		end
	end
	// Open-drain flag: pulled low while the pulse counter runs
	assign ready_o = 1'b0;
	assign ready_oe = (rdy_cnt != 3'h0);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence store_start_s;
		state == WNC_IDLE && do_store;
	endsequence
	store_lock_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		store_start_s |=> locked[*8]) else $error("store not locked");
	pulse_after_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		state == WNC_DONE |=> ready_oe) else $error("no completion pulse");
	preset_mid_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		pr_low |=> wiper_pos == `WNC_WIPER_MID) else $error("preset not midscale");
	protect_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		wp_on && !pr_low && !pr_rise && !do_restore && !boot |=> $stable(wiper_pos))
		else $error("protected wiper changed");
	release_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		!cs_low |-> !ser_out_oe) else $error("serial out driven");
	write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		do_write && !pr_low && !pr_rise && !boot
		|=> wiper_pos == $past(shift[`WNC_DATA_MSB:0])) else $error("direct write lost");
	incr_sat_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		do_adj && !pr_low && !pr_rise && !boot && cmd == 4'he && wiper_pos == `WNC_WIPER_MAX
		|=> wiper_pos == `WNC_WIPER_MAX) else $error("increment wrapped");
	restore_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		do_restore && !pr_low |=> wiper_pos == $past(nv_val)) else $error("restore lost");
	echo_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		frame_ok && cmd == 4'hb |=> echo == $past(shift)) else $error("echo wrong");
	// Step and shift checks
	dec_sat_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		do_adj && !pr_low && !pr_rise && (cmd == 4'h6 || cmd == 4'h7)
		&& wiper_pos == `WNC_WIPER_MIN |=> wiper_pos == `WNC_WIPER_MIN)
		else $error("decrement wrapped");
	halve_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		do_adj && !pr_low && !pr_rise && (cmd == 4'h4 || cmd == 4'h5)
		|=> wiper_pos == ($past(wiper_pos) >> 1)) else $error("halving wrong");
	sequence repeat_strobe_s;
		strobe_rep && !wp_on && !pr_low && !pr_rise;
	endsequence
	repeat_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		repeat_strobe_s |=> wiper_pos == adjust($past(wiper_pos), $past(last_cmd)))
		else $error("strobe repeat wrong");
	// Serial path and completion checks
	readback_data_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		frame_ok && cmd == 4'h9 |=> echo == {14'h0000, $past(nv_val)})
		else $error("readback wrong");
	shift_lock_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		locked && clk_rise |=> $stable(shift)) else $error("shifter not locked");
	frame_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		cs_rise && got_bits && bit_cnt != 5'h00 && !pr_low && !pr_rise
		|=> $stable(wiper_pos)) else $error("short frame executed");
	restore_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		do_restore |=> ready_oe) else $error("no restore completion flag");
endmodule // wnc_ctrl
`default_nettype wire

// ### test/wnc_host.sv
// Host side serial master model for the wiper command controller.
// Assumes a pulled-up data return line and a link period of 8 core cycles.
`timescale 1ns/1ns
`default_nettype none
module wnc_host (
	input wire logic core_clk,
	input wire logic sdo_oe,
	output logic link_clk,
	output logic chip_sel_n,
	output logic ser_in,
	output logic [23:0] got
);
	// Idle: link clock parked low, select high, clock still between frames
	initial begin
		link_clk = 1'b0;
		chip_sel_n = 1'b1;
		ser_in = 1'b1;
		got = 24'h000000;
	end
	// Half a link period, changes land on falling core edges
	task automatic half();
		repeat (4) @(negedge core_clk);
	endtask
	// first nbits bits of the frame, msb first; nbits of 0 makes an empty strobe
	task automatic xfer(input logic [23:0] f, input int nbits);
		chip_sel_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			ser_in = f[23 - i];
			half();
			link_clk = 1'b1;
			// Pulled-up line reads low only while the device pulls it
			got = {got[22:0], ~sdo_oe};
			half();
			link_clk = 1'b0;
		end
		half();
		chip_sel_n = 1'b1;
		// Released data line shows the inverse, never a stale level
		ser_in = ~ser_in;
		repeat (8) @(negedge core_clk);
	endtask
endmodule // wnc_host
`default_nettype wire

// ### test/wiper_nv_command_control_bench.sv
// Self-checking bench of the wiper command controller.
// Assumes wnc_host drives the serial pins; store shortened to 400 cycles.
`timescale 1ns/1ns
`default_nettype none
module wiper_nv_command_control_bench import wnc_pkg::*;;
	logic core_clk, reset_n, write_prot_n, preset_strobe_n;
	logic link_clk, chip_sel_n, ser_in, ser_out_o, ser_out_oe, ready_o, ready_oe;
	wnc_wiper_t wiper_pos;
	logic [15:0] program_cycles;
	logic [23:0] got;
	int failures = 0;
	int checks = 0;
	int ready_pulses = 0;
	// Completion pulses seen on the open-drain flag
	always @(posedge ready_oe) ready_pulses++;
	wnc_ctrl #(.STORE_CYC(400)) u_wnc_ctrl (.core_clk(core_clk), .reset_n(reset_n),
		.link_clk(link_clk), .chip_sel_n(chip_sel_n), .ser_in(ser_in), .ser_out_o(ser_out_o),
		.ser_out_oe(ser_out_oe), .write_prot_n(write_prot_n),
		.preset_strobe_n(preset_strobe_n), .ready_o(ready_o), .ready_oe(ready_oe),
		.wiper_pos(wiper_pos), .program_cycles(program_cycles));
	wnc_host u_wnc_host (.core_clk(core_clk), .sdo_oe(ser_out_oe), .link_clk(link_clk),
		.chip_sel_n(chip_sel_n), .ser_in(ser_in), .got(got));
	// Core clock, 100 ns period
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Compare and count
	task automatic chk(input logic [23:0] a, input logic [23:0] e);
		checks++;
		if (a !== e) begin
			failures++;
			$display("[ERR] t=%0t got %h exp %h", $time, a, e);
		end
	endtask
	task automatic give_verdict();
		if (failures == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Bounded wait for the completion pulse, then check its width
	task automatic wait_ready();
		int n;
		n = 0;
		while (ready_oe !== 1'b1 && n < 1000) begin
			@(negedge core_clk);
			n++;
		end
		if (ready_oe !== 1'b1) begin
			failures++;
			$display("[ERR] t=%0t ready %h exp %h", $time, ready_oe, 1'b1);
			give_verdict();
		end else begin
			repeat (3) @(negedge core_clk);
			chk(ready_oe, 1);
			@(negedge core_clk);
			chk(ready_oe, 0);
		end
	endtask
	// Write, store, then a frame sent into the locked store window
	task automatic s_store();
		u_wnc_host.xfer(24'hb00100, 24);
		chk(wiper_pos, 24'h100);
		u_wnc_host.xfer(24'h200000, 24);
		chk(got, 24'hb00100);
		u_wnc_host.xfer(24'hb003ff, 24);
		chk(wiper_pos, 24'h100);
		wait_ready();
		chk(program_cycles, 24'h1);
	endtask
	// Step, halve, double, one repeat strobe and saturation at both ends
	task automatic s_steps();
		logic [23:0] fr [13] = '{24'hb003fe, 24'he00000, 24'hf00000, 24'h600000, 24'h0,
			24'h400000, 24'hc00000, 24'hd00000, 24'h500000, 24'h700000, 24'hb00001,
			24'h400000, 24'h700000};
		int nb [13] = '{24, 24, 24, 24, 0, 24, 24, 24, 24, 24, 24, 24, 24};
		logic [23:0] ex [13] = '{24'h3fe, 24'h3ff, 24'h3ff, 24'h3fe, 24'h3fd, 24'h1fe,
			24'h3fc, 24'h3ff, 24'h1ff, 24'h1fe, 24'h1, 24'h0, 24'h0};
		for (int i = 0; i < 13; i++) begin
			u_wnc_host.xfer(fr[i], nb[i]);
			chk(wiper_pos, ex[i]);
		end
	endtask
	// Both restore codes and both readbacks
	task automatic s_restore();
		int p;
		p = ready_pulses;
		u_wnc_host.xfer(24'hb00123, 24);
		u_wnc_host.xfer(24'h100000, 24);
		chk(wiper_pos, 24'h100);
		u_wnc_host.xfer(24'hb00123, 24);
		u_wnc_host.xfer(24'h800000, 24);
		chk(wiper_pos, 24'h100);
		u_wnc_host.xfer(24'h900000, 24);
		u_wnc_host.xfer(24'hb00077, 24);
		chk(got, 24'h000100);
		u_wnc_host.xfer(24'ha00000, 24);
		u_wnc_host.xfer(24'h000000, 24);
		chk(got, 24'h000077);
		chk(24'(ready_pulses - p), 24'h4);
	endtask
	// Protected writes, steps and stores refused; restore still works
	task automatic s_protect();
		int p;
		p = ready_pulses;
		write_prot_n = 1'b0;
		u_wnc_host.xfer(24'hb00055, 24);
		chk(wiper_pos, 24'h77);
		u_wnc_host.xfer(24'he00000, 24);
		chk(wiper_pos, 24'h77);
		u_wnc_host.xfer(24'h200000, 24);
		chk(program_cycles, 24'h1);
		u_wnc_host.xfer(24'h100000, 24);
		chk(wiper_pos, 24'h100);
		u_wnc_host.xfer(24'h000000, 24);
		write_prot_n = 1'b1;
		u_wnc_host.xfer(24'hb00055, 24);
		chk(wiper_pos, 24'h55);
		chk(24'(ready_pulses - p), 24'h1);
	endtask
	// Short frame dropped, then preset strobe
	task automatic s_preset();
		int p;
		u_wnc_host.xfer(24'hb00222, 23);
		chk(wiper_pos, 24'h55);
		p = ready_pulses;
		preset_strobe_n = 1'b0;
		repeat (8) @(negedge core_clk);
		chk(wiper_pos, 24'h200);
		preset_strobe_n = 1'b1;
		repeat (8) @(negedge core_clk);
		chk(wiper_pos, 24'h100);
		chk(24'(ready_pulses - p), 24'h1);
	endtask
	// Code 3 stores only with address zero; code 8 then restores it
	task automatic s_user_store();
		u_wnc_host.xfer(24'h310002, 24);
		u_wnc_host.xfer(24'hb00155, 24);
		chk(wiper_pos, 24'h155);
		u_wnc_host.xfer(24'h300000, 24);
		wait_ready();
		chk(program_cycles, 24'h2);
		u_wnc_host.xfer(24'hb00011, 24);
		u_wnc_host.xfer(24'h800000, 24);
		chk(wiper_pos, 24'h155);
	endtask
	// Main sequence: reset held 8 cycles, inputs change on falling edges
	initial begin
		reset_n = 1'b0;
		write_prot_n = 1'b1;
		preset_strobe_n = 1'b1;
		repeat (8) @(negedge core_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge core_clk);
		chk(wiper_pos, 24'h200);
		chk(ser_out_oe, 0);
		chk(ser_out_o, 0);
		chk(ready_o, 0);
		chk(ready_oe, 0);
		s_store();
		s_steps();
		s_restore();
		s_protect();
		s_preset();
		s_user_store();
		give_verdict();
	end
endmodule // wiper_nv_command_control_bench
`default_nettype wire
